// [lpsq_pkg.sv]
// Function
// - Coded idle entry sends sequences 8 us
// - Uncoded idle entry forwards core data 8 us
// - Then enter idle state, report status
// - Wait 1 ms before enabling signal detect
// - Coded entry ignores core data, sends sequences
// - Non-initiator retrains on incoming detect sequences
// - Core exit request starts detect training sequences
// - Remote receiver answers with detect sequences
// - Training done after idle exit reports up
// - Coded reduced entry sends identifier with handshake
// - Uncoded reduced entry or exit forwards 1 us
// - Then start retraining for entry and exit
// - Degraded configuration reached enters reduced state
// - Coded reduced exit sends up identifier, handshake
// - Full operation retrained enters up, reports
// - Four-bit state codes: up, reduced, idle
// - Send four, receive two matching before stopping
// - Identifier: code four times, inverse then true
// - Exit beats entry, reduced beats idle, lower wins
package lpsq_pkg;

    localparam int CLK_PERIOD_NS = 40;
    localparam int IDLE_TX_NS = 8000;
    localparam int UP_TX_NS = 1000;
    localparam int RX_WAIT_MS = 1;
    // Least times round up to whole cycles
    localparam int IDLE_TX_CYC = (IDLE_TX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UP_TX_CYC = (UP_TX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RX_WAIT_CYC = (RX_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 16;

    localparam logic [3:0] CODE_UP = 4'h0;
    localparam logic [3:0] CODE_UPLP_FIRST = 4'h1;
    localparam logic [3:0] CODE_UPLP_LAST = 4'h4;
    localparam logic [3:0] CODE_IDLE_FIRST = 4'h9;
    localparam logic [3:0] CODE_IDLE_LAST = 4'hc;
    localparam logic [3:0] RANK_NONE = 4'hf;
    localparam logic [3:0] STATUS_RST = 4'h0;

    localparam int MIN_SENT = 4;
    localparam int MIN_RECV = 2;
    localparam int HS_CNT_W = 3;

    typedef enum logic [2:0] {
        TX_NONE,
        TX_DATA,
        TX_LP_SEQ,
        TX_SD_TS,
        TX_TRAIN
    } lpsq_tx_kind_t;

    typedef enum logic [2:0] {
        ST_UP,
        ST_IDLE_TX,
        ST_IDLE_LP,
        ST_SD_TX,
        ST_UPLP_TX,
        ST_RETRAIN,
        ST_UPLP
    } lpsq_state_t;

    typedef struct packed {
        logic valid;
        logic [3:0] code;
    } lpsq_req_t;

    typedef struct packed {
        lpsq_tx_kind_t kind;
        logic [31:0] low_power_identifier;
    } lpsq_tx_t;

endpackage

// [lpsq_seq_tracker.sv]
`timescale 1ns/1ps
`default_nettype none
module lpsq_seq_tracker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic [3:0] code,
    input wire logic active,
    input wire logic tx_seq_sent,
    input wire lpsq_pkg::lpsq_req_t rx_seq,
    output logic hs_done,
    output logic [31:0] low_power_identifier
);
    logic [lpsq_pkg::HS_CNT_W-1:0] sent_reg;
    logic [lpsq_pkg::HS_CNT_W-1:0] recv_reg;
    logic [15:0] n_word;
    wire logic sent_full = sent_reg >= lpsq_pkg::HS_CNT_W'(lpsq_pkg::MIN_SENT);
    wire logic recv_full = recv_reg >= lpsq_pkg::HS_CNT_W'(lpsq_pkg::MIN_RECV);
    wire logic rx_match = active && rx_seq.valid && (rx_seq.code == code);

    assign hs_done = sent_full && recv_full;
    assign n_word = {code, code, code, code};

    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1)
        begin : g_low_power_identifier
            assign low_power_identifier[2*i+1] = ~n_word[i];
            assign low_power_identifier[2*i] = n_word[i];
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sent_reg <= '0;
            recv_reg <= '0;
        end
        else if (clear)
        begin
            sent_reg <= '0;
            recv_reg <= '0;
        end
        else
        begin
            if (active && tx_seq_sent && !sent_full)
                sent_reg <= sent_reg + 1'b1;
            if (rx_match && !recv_full)
                recv_reg <= recv_reg + 1'b1;
        end
    end
endmodule // lpsq_seq_tracker
`default_nettype wire

// [lpsq_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module lpsq_sequencer #(
    parameter int DATA_W = 64,
    parameter int IDLE_TX_CYC = lpsq_pkg::IDLE_TX_CYC,
    parameter int UP_TX_CYC = lpsq_pkg::UP_TX_CYC,
    parameter int RX_WAIT_CYC = lpsq_pkg::RX_WAIT_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire lpsq_pkg::lpsq_req_t core_req,
    input wire logic line_coding_en,
    input wire logic [DATA_W-1:0] core_tx_data,
    input wire logic tx_seq_sent,
    input wire lpsq_pkg::lpsq_req_t rx_seq,
    input wire logic rx_sd_ts_detect,
    input wire logic train_done,
    input wire logic train_degraded,
    output logic [3:0] status_code,
    output lpsq_pkg::lpsq_tx_t tx_ctl,
    output logic [DATA_W-1:0] tx_data,
    output logic rx_sig_det_en,
    output logic train_start
);
    ////////////////////////////////////////////////////////////////////////////
    // Request ranking
    function automatic logic [3:0] lpsq_rank(input logic [3:0] c);
        if (c == lpsq_pkg::CODE_UP)
            return 4'h0;
        else if (c >= lpsq_pkg::CODE_UPLP_FIRST && c <= lpsq_pkg::CODE_UPLP_LAST)
            return c;
        else if (c >= lpsq_pkg::CODE_IDLE_FIRST && c <= lpsq_pkg::CODE_IDLE_LAST)
            return c - 4'h4;
        else
            return lpsq_pkg::RANK_NONE;
    endfunction

    lpsq_pkg::lpsq_state_t state_reg;
    lpsq_pkg::lpsq_state_t state_next;
    logic [3:0] target_reg;
    logic coding_reg;
    logic [lpsq_pkg::TMR_W-1:0] tmr_reg;
    logic [3:0] status_reg;
    lpsq_pkg::lpsq_tx_t tx_reg;
    logic [DATA_W-1:0] txd_reg;
    logic rx_en_reg;
    logic train_reg;
    logic hs_done;
    logic [31:0] trk_low_power_identifier;
    lpsq_pkg::lpsq_tx_kind_t kind_next;
    logic [lpsq_pkg::TMR_W-1:0] tmr_load;

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration between the core and the remote end
    wire logic [3:0] core_rank = core_req.valid ? lpsq_rank(core_req.code) : lpsq_pkg::RANK_NONE;
    wire logic rx_ok = rx_seq.valid && line_coding_en;
    wire logic [3:0] rx_rank = rx_ok ? lpsq_rank(rx_seq.code) : lpsq_pkg::RANK_NONE;
    wire logic pick_rx = rx_rank < core_rank;
    wire logic [3:0] win_code = pick_rx ? rx_seq.code : core_req.code;
    wire logic [3:0] win_rank = pick_rx ? rx_rank : core_rank;
    wire logic win_valid = win_rank != lpsq_pkg::RANK_NONE;
    wire logic win_exit = win_valid && win_code == lpsq_pkg::CODE_UP;
    wire logic win_uplp = win_valid && win_rank >= 4'h1 && win_rank <= 4'h4;
    wire logic win_idle = win_valid && win_rank >= 4'h5 && win_rank <= 4'h8;
    wire logic tmr_zero = tmr_reg == '0;
    wire logic entering = state_next != state_reg;
    wire logic accept = (state_reg == lpsq_pkg::ST_UP && (win_uplp || win_idle))
        || (state_reg == lpsq_pkg::ST_UPLP && win_exit);

    ////////////////////////////////////////////////////////////////////////////
    // State sequencing
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            lpsq_pkg::ST_UP:
                if (win_uplp)
                    state_next = lpsq_pkg::ST_UPLP_TX;
                else if (win_idle)
                    state_next = lpsq_pkg::ST_IDLE_TX;
            lpsq_pkg::ST_IDLE_TX:
                if (tmr_zero)
                    state_next = lpsq_pkg::ST_IDLE_LP;
            lpsq_pkg::ST_IDLE_LP:
                if (core_req.valid && core_req.code == lpsq_pkg::CODE_UP)
                    state_next = lpsq_pkg::ST_SD_TX;
                else if (rx_en_reg && rx_sd_ts_detect)
                    state_next = lpsq_pkg::ST_SD_TX;
            lpsq_pkg::ST_SD_TX:
                if (train_done)
                    state_next = lpsq_pkg::ST_UP;
            lpsq_pkg::ST_UPLP_TX:
                if (coding_reg ? hs_done : tmr_zero)
                    state_next = lpsq_pkg::ST_RETRAIN;
            lpsq_pkg::ST_RETRAIN:
                if (target_reg != lpsq_pkg::CODE_UP && train_degraded)
                    state_next = lpsq_pkg::ST_UPLP;
                else if (target_reg == lpsq_pkg::CODE_UP && train_done)
                    state_next = lpsq_pkg::ST_UP;
            lpsq_pkg::ST_UPLP:
                if (win_exit)
                    state_next = lpsq_pkg::ST_UPLP_TX;
            default:
                state_next = lpsq_pkg::ST_UP;
        endcase
    end

    // Coded idle entry sends sequences; uncoded paths forward core data
    always_comb
    begin
        kind_next = lpsq_pkg::TX_DATA;
        case (state_next)
            lpsq_pkg::ST_IDLE_TX, lpsq_pkg::ST_UPLP_TX:
                kind_next = line_coding_sel() ? lpsq_pkg::TX_LP_SEQ : lpsq_pkg::TX_DATA;
            lpsq_pkg::ST_IDLE_LP:
                kind_next = lpsq_pkg::TX_NONE;
            lpsq_pkg::ST_SD_TX:
                kind_next = lpsq_pkg::TX_SD_TS;
            lpsq_pkg::ST_RETRAIN:
                kind_next = lpsq_pkg::TX_TRAIN;
            default:
                kind_next = lpsq_pkg::TX_DATA;
        endcase
    end

    function automatic logic line_coding_sel();
        return accept ? line_coding_en : coding_reg;
    endfunction

    assign tmr_load = (state_next == lpsq_pkg::ST_IDLE_TX)
        ? lpsq_pkg::TMR_W'(IDLE_TX_CYC - 1)
        : (state_next == lpsq_pkg::ST_UPLP_TX) ? lpsq_pkg::TMR_W'(UP_TX_CYC - 1)
        : lpsq_pkg::TMR_W'(RX_WAIT_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= lpsq_pkg::ST_UP;
            target_reg <= lpsq_pkg::CODE_UP;
            coding_reg <= 1'b0;
            tmr_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            if (accept)
            begin
                target_reg <= win_code;
                coding_reg <= line_coding_en;
            end
            if (entering)
                tmr_reg <= tmr_load;
            else if (!tmr_zero)
                tmr_reg <= tmr_reg - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_reg <= lpsq_pkg::STATUS_RST;
            tx_reg <= '{kind: lpsq_pkg::TX_DATA, low_power_identifier: 32'h0};
            txd_reg <= '0;
            rx_en_reg <= 1'b0;
            train_reg <= 1'b0;
        end
        else
        begin
            if (entering && state_next == lpsq_pkg::ST_IDLE_LP)
                status_reg <= target_reg;
            else if (entering && state_next == lpsq_pkg::ST_UPLP)
                status_reg <= target_reg;
            else if (entering && state_next == lpsq_pkg::ST_UP)
                status_reg <= lpsq_pkg::CODE_UP;
            tx_reg.kind <= kind_next;
            tx_reg.low_power_identifier <= trk_low_power_identifier;
            txd_reg <= core_tx_data;
            rx_en_reg <= state_reg == lpsq_pkg::ST_IDLE_LP && !entering && tmr_zero;
            train_reg <= entering && (state_next == lpsq_pkg::ST_RETRAIN
                || state_next == lpsq_pkg::ST_SD_TX);
        end
    end

    lpsq_seq_tracker u_trk (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clear(accept),
        .code(accept ? win_code : target_reg),
        .active(state_reg == lpsq_pkg::ST_UPLP_TX),
        .tx_seq_sent(tx_seq_sent),
        .rx_seq(rx_seq),
        .hs_done(hs_done),
        .low_power_identifier(trk_low_power_identifier)
    );

    assign status_code = status_reg;
    assign tx_ctl = tx_reg;
    assign tx_data = txd_reg;
    assign rx_sig_det_en = rx_en_reg;
    assign train_start = train_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [lpsq_pkg::TMR_W-1:0] dwell_reg;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            dwell_reg <= '0;
        else if (entering)
            dwell_reg <= '0;
        else
            dwell_reg <= dwell_reg + 1'b1;
    end

    idle_tx_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == lpsq_pkg::ST_IDLE_TX && state_next != state_reg
        |-> dwell_reg == lpsq_pkg::TMR_W'(IDLE_TX_CYC - 1))
        else $error("idle entry transmit interval wrong");

    uplp_tx_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == lpsq_pkg::ST_UPLP_TX && !coding_reg && state_next != state_reg
        |-> dwell_reg == lpsq_pkg::TMR_W'(UP_TX_CYC - 1))
        else $error("reduced transition forwarding interval wrong");

    rx_wait_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(rx_en_reg) |-> state_reg == lpsq_pkg::ST_IDLE_LP
        && dwell_reg >= lpsq_pkg::TMR_W'(RX_WAIT_CYC))
        else $error("signal detect enabled too early");

    idle_status_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(state_reg == lpsq_pkg::ST_IDLE_LP) |-> status_reg == target_reg)
        else $error("idle status not reported");

    handshake_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == lpsq_pkg::ST_UPLP_TX && coding_reg
        && state_next == lpsq_pkg::ST_RETRAIN |-> hs_done)
        else $error("sequence handshake cut short");

    low_power_identifier_form_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == lpsq_pkg::ST_UPLP_TX && !accept |=> tx_reg.low_power_identifier[31:30]
        == {~$past(target_reg[3]), $past(target_reg[3])}
        && tx_reg.low_power_identifier[1:0] == {~$past(target_reg[0]), $past(target_reg[0])})
        else $error("identifier layout wrong");

    exit_sd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == lpsq_pkg::ST_IDLE_LP && core_req.valid
        && core_req.code == lpsq_pkg::CODE_UP
        |=> tx_reg.kind == lpsq_pkg::TX_SD_TS && train_reg)
        else $error("exit did not start detect sequences");

    up_report_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_reg == lpsq_pkg::ST_SD_TX && train_done)
        |=> status_reg == lpsq_pkg::CODE_UP && state_reg == lpsq_pkg::ST_UP)
        else $error("up state not reported");

    prio_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        accept && rx_rank < core_rank |=> target_reg == $past(rx_seq.code))
        else $error("request priority wrong");

    coded_seq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == lpsq_pkg::ST_IDLE_TX && coding_reg
        |-> tx_reg.kind == lpsq_pkg::TX_LP_SEQ)
        else $error("core data sent during coded entry");

    // Sequences sent in the reduced transition, counted apart from the tracker
    logic [lpsq_pkg::HS_CNT_W-1:0] seen_sent_reg;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            seen_sent_reg <= '0;
        else if (entering)
            seen_sent_reg <= '0;
        else if (state_reg == lpsq_pkg::ST_UPLP_TX && tx_seq_sent && seen_sent_reg != '1)
            seen_sent_reg <= seen_sent_reg + 1'b1;
    end

    sent_count_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == lpsq_pkg::ST_UPLP_TX && coding_reg && state_next != state_reg
        |-> seen_sent_reg >= lpsq_pkg::HS_CNT_W'(lpsq_pkg::MIN_SENT))
        else $error("fewer sequences sent than required");

    retrain_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(state_reg == lpsq_pkg::ST_RETRAIN)
        |-> train_reg && tx_reg.kind == lpsq_pkg::TX_TRAIN)
        else $error("retraining not started");

    uplp_report_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == lpsq_pkg::ST_RETRAIN && target_reg != lpsq_pkg::CODE_UP && train_degraded
        |=> state_reg == lpsq_pkg::ST_UPLP && status_reg == $past(target_reg))
        else $error("reduced state not reported");

    wake_exit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == lpsq_pkg::ST_IDLE_LP && rx_en_reg && rx_sd_ts_detect
        |=> state_reg == lpsq_pkg::ST_SD_TX && tx_reg.kind == lpsq_pkg::TX_SD_TS && train_reg)
        else $error("no autonomous wake from idle");

    status_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        status_reg == lpsq_pkg::CODE_UP
        || (status_reg >= lpsq_pkg::CODE_UPLP_FIRST && status_reg <= lpsq_pkg::CODE_UPLP_LAST)
        || (status_reg >= lpsq_pkg::CODE_IDLE_FIRST && status_reg <= lpsq_pkg::CODE_IDLE_LAST))
        else $error("illegal status code");

    uncoded_fwd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == lpsq_pkg::ST_IDLE_TX && !coding_reg
        |-> tx_reg.kind == lpsq_pkg::TX_DATA && txd_reg == $past(core_tx_data))
        else $error("core data not forwarded");
endmodule // lpsq_sequencer
`default_nettype wire

// [lpsq_far_end.sv]
`timescale 1ns/1ps
`default_nettype none
module lpsq_far_end #(
    parameter int SEQ_GAP = 3,
    parameter int TRAIN_DLY = 12
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire lpsq_pkg::lpsq_tx_t tx_ctl,
    input wire logic train_start,
    input wire logic degrade,
    input wire logic wake,
    output logic tx_seq_sent,
    output lpsq_pkg::lpsq_req_t rx_seq,
    output logic rx_sd_ts_detect,
    output logic train_done,
    output logic train_degraded
);
    int gap_cnt;
    int train_cnt;
    logic [3:0] seen_code;
    assign seen_code = {tx_ctl.low_power_identifier[30], tx_ctl.low_power_identifier[28], tx_ctl.low_power_identifier[26], tx_ctl.low_power_identifier[24]};
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gap_cnt <= 0;
            train_cnt <= 0;
            tx_seq_sent <= 1'b0;
            rx_seq <= '0;
            rx_sd_ts_detect <= 1'b0;
            train_done <= 1'b0;
            train_degraded <= 1'b0;
        end
        else
        begin
            tx_seq_sent <= 1'b0;
            train_done <= 1'b0;
            train_degraded <= 1'b0;
            // Released code lines toggle so a stale value never looks valid
            rx_seq <= '{1'b0, ~rx_seq.code};
            // Remote answers our detect sequences with its own
            rx_sd_ts_detect <= wake || tx_ctl.kind == lpsq_pkg::TX_SD_TS;
            // Serializer finishes one sequence every SEQ_GAP + 1 cycles
            if (tx_ctl.kind == lpsq_pkg::TX_LP_SEQ)
            begin
                gap_cnt <= (gap_cnt == SEQ_GAP) ? 0 : gap_cnt + 1;
                tx_seq_sent <= (gap_cnt == SEQ_GAP);
            end
            // Remote echoes each sequence with the code it decoded
            if (tx_seq_sent)
                rx_seq <= '{1'b1, seen_code};
            if (train_start)
                train_cnt <= TRAIN_DLY;
            else if (train_cnt > 0)
                train_cnt <= train_cnt - 1;
            if (train_cnt == 1)
            begin
                train_done <= !degrade;
                train_degraded <= degrade;
            end
        end
    end
endmodule // lpsq_far_end
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int IDLE_CYC = 20;
    localparam int UP_CYC = 5;
    localparam int WAIT_CYC = 30;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    lpsq_pkg::lpsq_req_t core_req = '0;
    lpsq_pkg::lpsq_req_t inject = '0;
    lpsq_pkg::lpsq_req_t far_seq;
    lpsq_pkg::lpsq_req_t rx_seq;
    logic line_coding_en = 1'b0;
    logic [63:0] core_tx_data = 64'h0;
    logic degrade = 1'b0;
    logic wake = 1'b0;
    logic tx_seq_sent, rx_sd_ts_detect, train_done, train_degraded;
    logic [3:0] status_code;
    lpsq_pkg::lpsq_tx_t tx_ctl;
    logic [63:0] tx_data;
    logic rx_sig_det_en, train_start;
    int fails = 0;
    int checks_done = 0;
    int seq_cnt = 0;
    int starts = 0;
    assign rx_seq = inject.valid ? inject : far_seq;
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        if (tx_seq_sent === 1'b1)
            seq_cnt++;
        if (train_start === 1'b1)
            starts++;
    end
    lpsq_sequencer #(.IDLE_TX_CYC(IDLE_CYC), .UP_TX_CYC(UP_CYC), .RX_WAIT_CYC(WAIT_CYC)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .core_req(core_req),
        .line_coding_en(line_coding_en), .core_tx_data(core_tx_data),
        .tx_seq_sent(tx_seq_sent), .rx_seq(rx_seq), .rx_sd_ts_detect(rx_sd_ts_detect),
        .train_done(train_done), .train_degraded(train_degraded), .status_code(status_code),
        .tx_ctl(tx_ctl), .tx_data(tx_data), .rx_sig_det_en(rx_sig_det_en),
        .train_start(train_start)
    );
    lpsq_far_end far (
        .core_clk(core_clk), .rst_n(rst_n), .tx_ctl(tx_ctl), .train_start(train_start),
        .degrade(degrade), .wake(wake), .tx_seq_sent(tx_seq_sent), .rx_seq(far_seq),
        .rx_sd_ts_detect(rx_sd_ts_detect), .train_done(train_done),
        .train_degraded(train_degraded)
    );
    ////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    function automatic logic [31:0] low_power_identifier_of(input logic [3:0] c);
        logic [31:0] r;
        for (int i = 0; i < 16; i++)
            r[2*i+:2] = {~c[i%4], c[i%4]};
        return r;
    endfunction
    function automatic logic hit(input int what, input logic [3:0] v);
        case (what)
            0: return tx_ctl.kind === lpsq_pkg::lpsq_tx_kind_t'(v[2:0]);
            1: return status_code === v;
            default: return rx_sig_det_en === v[0];
        endcase
    endfunction
    // Bounded wait; a bound used up ends the run
    task automatic wait_for(input int what, input logic [3:0] v, input int bound, output int n);
        n = 0;
        while (!hit(what, v) && n < bound)
        begin
            step(1);
            n++;
        end
        if (!hit(what, v))
        begin
            chk(1'b0, "timeout");
            give_verdict();
        end
    endtask
    task automatic send(input logic [3:0] c);
        core_req = '{1'b1, c};
        step(1);
        core_req.valid = 1'b0;
    endtask
    // One leg of a reduced-state move: send phase, retrain, report
    task automatic leg(input logic [3:0] c, input logic coded, input logic [3:0] want);
        int n;
        int base;
        if (coded)
        begin
            wait_for(0, 4'(lpsq_pkg::TX_LP_SEQ), 4, n);
            chk(tx_ctl.low_power_identifier === low_power_identifier_of(c), "sequence identifier");
        end
        base = seq_cnt;
        wait_for(0, 4'(lpsq_pkg::TX_TRAIN), 80, n);
        if (coded)
            chk(seq_cnt - base >= lpsq_pkg::MIN_SENT, "too few sequences");
        else
            chk(n >= UP_CYC - 1 && n <= UP_CYC + 2, "forward time");
        base = starts;
        wait_for(1, want, 40, n);
        chk(starts - base == 1, "retrain start");
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic idle_coded();
        int n;
        line_coding_en = 1'b1;
        send(4'h9);
        wait_for(0, 4'(lpsq_pkg::TX_LP_SEQ), 4, n);
        chk(tx_ctl.low_power_identifier === low_power_identifier_of(4'h9), "idle identifier");
        wait_for(1, 4'h9, IDLE_CYC + 4, n);
        chk(n >= IDLE_CYC - 1 && n <= IDLE_CYC + 1, "idle send time");
        chk(rx_sig_det_en === 1'b0, "detect enabled early");
        wait_for(2, 4'h1, WAIT_CYC + 4, n);
        chk(n >= WAIT_CYC - 1 && n <= WAIT_CYC + 1, "detect wait");
        send(4'h0);
        wait_for(0, 4'(lpsq_pkg::TX_SD_TS), 4, n);
        wait_for(1, 4'h0, 40, n);
        step(1);
        chk(tx_ctl.kind === lpsq_pkg::TX_DATA, "data after exit");
        $display("idle_coded finished");
    endtask
    task automatic idle_wake();
        int n;
        line_coding_en = 1'b0;
        send(4'hc);
        step(1);
        chk(tx_ctl.kind === lpsq_pkg::TX_DATA, "uncoded kind");
        core_tx_data = 64'h0123_4567_89ab_cdef;
        step(1);
        chk(tx_data === 64'h0123_4567_89ab_cdef, "forwarded data");
        wait_for(1, 4'hc, IDLE_CYC + 4, n);
        chk(n + 2 >= IDLE_CYC - 1 && n + 2 <= IDLE_CYC + 2, "uncoded time");
        wait_for(2, 4'h1, WAIT_CYC + 4, n);
        wake = 1'b1;
        step(1);
        wake = 1'b0;
        wait_for(0, 4'(lpsq_pkg::TX_SD_TS), 4, n);
        wait_for(1, 4'h0, 40, n);
        send(4'h0);
        chk(status_code === 4'h0 && tx_ctl.kind === lpsq_pkg::TX_DATA, "up request held");
        $display("idle_wake finished");
    endtask
    task automatic reduced(input logic [3:0] c, input logic coded, input logic clash);
        line_coding_en = coded;
        degrade = 1'b1;
        if (clash)
        begin
            core_req = '{1'b1, 4'ha};
            inject = '{1'b1, c};
            step(1);
            core_req.valid = 1'b0;
            inject.valid = 1'b0;
        end
        else
            send(c);
        leg(c, coded, c);
        degrade = 1'b0;
        send(4'h0);
        leg(4'h0, coded, 4'h0);
        $display("reduced %0h finished", c);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge core_clk);
        #1;
        chk(status_code === 4'h0 && tx_ctl.kind === lpsq_pkg::TX_DATA, "reset");
        rst_n = 1'b1;
        step(1);
        idle_coded();
        idle_wake();
        reduced(4'h2, 1'b1, 1'b0);
        reduced(4'h4, 1'b0, 1'b0);
        reduced(4'h1, 1'b1, 1'b1);
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
